/* File: rtl/host_port.sv */
// host_port.sv - serial and parallel host port pins of the device
// assumes: all pins but irqSrc and rst_n asynchronous to clk, shift clock well below clk/8
// How it works
// - serial input bit taken on each rising shift clock edge
// - strobe style: byte written at rising edge of write strobe
// - direction style write: byte taken at rising edge of data strobe
// - direction style read: bus driven from rising edge of data strobe
// - direction non-mux: address taken from address bus at data strobe fall
// - hardware control mode ignores serial input and all strobes
// - serial write keeps serial output released throughout
// - serial read releases output during command byte, drives after
// - output edge select high: shift on fall; low: shift on rise
// - ready high lets cycle finish, low asks for wait states
// - acknowledge low marks valid read data or accepted write
// - open-drain active-low interrupt when any of three sources active
// - style select low: direction style; high: split strobe style
// - mux mode: address from low five bus lines at strobe fall
`timescale 1ns/1ps
`include "host_port_defs.svh"
module host_port (
   input wire logic clk, // system clock, 40 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic hwMode, // hardware control mode strap
   input wire logic serialMode, // serial host mode when high
   input wire logic muxMode, // multiplexed bus when high
   input wire logic busStyleSelect, // 0 direction style, 1 split strobes
   input wire logic outputEdgeSelect, // serial output edge select
   input wire logic csN, // chip select, active low
   input wire logic sclkAleAsN, // shift clock / address latch / addr_strobe_n
   input wire logic serialIn, // serial_in / write strobe / data_strobe_n
   input wire logic rdNRw, // read strobe / read-write select
   input wire logic [4:0] addrIn, // separate address bus
   input wire logic [7:0] dataIn, // data bus, input side
   output host_port_pkg::byte_t dataOut, // data bus, output side
   output logic dataOe, // data bus drive enable
   output logic serialOut, // serial_out / ready / acknowledge
   output logic serialOutEn, // drive enable of that pin
   input wire logic [2:0] irqSrc, // interrupt sources, same clock
   output logic intOut, // interrupt pin level, always low
   output logic intOe // interrupt pin pull-down enable
);
   import host_port_pkg::*;
   typedef struct packed {
      logic [`PIN_W-1:0] s1;
      logic [`PIN_W-1:0] s2;
      logic [`PIN_W-1:0] s3;
      phase_t ph;
      logic [3:0] cnt;
      logic isRead;
      logic [4:0] addr;
      byte_t shIn;
      byte_t shOut;
      byte_t dOut;
      byte_t wData;
      logic dOe;
      logic ackN;
      logic rdy;
      logic soEn;
      logic so;
      logic we;
      logic re;
      logic load;
   } st_t;

   st_t stReg, stNext;
   byte_t rdData;
   logic [`PIN_W-1:0] pins;

   ////////////////////////////////////////////////////////////////
   // pin gathering
   assign pins = {1'b0, outputEdgeSelect, busStyleSelect, muxMode, serialMode, hwMode,
                  csN, sclkAleAsN, serialIn, rdNRw, addrIn, dataIn};

   // edge finders on the synchronised copies
   function automatic logic rose(input st_t s, input int i);
      rose = s.s2[i] & ~s.s3[i];
   endfunction
   function automatic logic fell(input st_t s, input int i);
      fell = ~s.s2[i] & s.s3[i];
   endfunction

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic cs;
      logic hw;
      logic shEdge;
      byte_t newByte;
      cs = 1'b0;
      hw = 1'b0;
      shEdge = 1'b0;
      newByte = 8'h00;
      stNext = stReg;
      stNext.s1 = pins;
      stNext.s2 = stReg.s1;
      stNext.s3 = stReg.s2;
      stNext.we = 1'b0;
      stNext.re = 1'b0;
      stNext.load = stReg.re;
      cs = ~stReg.s2[`P_CS];
      hw = stReg.s2[`P_HW];
      newByte = {stReg.shIn[6:0], stReg.s2[`P_SIN]};
      if (hw || !cs) begin
         stNext.ph = PH_IDLE;
         stNext.cnt = 4'h0;
         stNext.dOe = 1'b0;
         stNext.soEn = 1'b0;
         stNext.ackN = 1'b1;
         stNext.rdy = 1'b1;
         stNext.isRead = 1'b0;
      end else if (stReg.s2[`P_SER]) begin
         // serial: command byte then data byte, msb first
         if (stReg.ph == PH_IDLE) begin
            stNext.ph = PH_CMD;
            stNext.cnt = 4'h0;
         end
         if (rose(stReg, `P_SCLK)) begin
            stNext.shIn = newByte;
            stNext.cnt = stReg.cnt + 4'h1;
            if (stReg.ph == PH_CMD && stReg.cnt == `BITS_LAST_CMD) begin
               stNext.isRead = stReg.shIn[6];
               stNext.addr = newByte[4:0];
               stNext.ph = PH_DATA;
               stNext.re = stReg.shIn[6];
            end
            if (stReg.ph == PH_DATA && stReg.cnt == `BITS_LAST_DATA && !stReg.isRead) begin
               stNext.we = 1'b1;
               stNext.wData = newByte;
            end
         end
         // output edge select picks the shifting edge
         shEdge = stReg.s2[`P_OES] ? (fell(stReg, `P_SCLK) && stReg.cnt != `CNT_FIRST_DATA)
                                   : rose(stReg, `P_SCLK);
         if (stReg.load) begin
            stNext.shOut = rdData;
         end else if (shEdge && stReg.ph == PH_DATA && stReg.isRead) begin
            stNext.shOut = {stReg.shOut[6:0], 1'b0};
         end
         stNext.soEn = (stNext.ph == PH_DATA) && stNext.isRead;
         stNext.so = stNext.shOut[7];
      end else if (!stReg.s2[`P_STYLE]) begin
         // direction style: serialIn is data strobe, rdNRw is read/write
         if (stReg.s2[`P_MUX] && fell(stReg, `P_SCLK)) begin
            stNext.addr = stReg.s2[`P_DATA +: 5];
         end
         if (!stReg.s2[`P_MUX] && fell(stReg, `P_SIN)) begin
            stNext.addr = stReg.s2[`P_ADDR +: 5];
         end
         if (fell(stReg, `P_SIN) && stReg.s2[`P_RW]) begin
            stNext.re = 1'b1;
         end
         if (stReg.load) begin
            stNext.dOut = rdData;
         end
         if (rose(stReg, `P_SIN)) begin
            if (stReg.s2[`P_RW]) begin
               stNext.dOe = 1'b1;
               stNext.ph = PH_DRIVE;
            end else begin
               stNext.we = 1'b1;
               stNext.wData = stReg.s2[`P_DATA +: 8];
            end
            stNext.ackN = 1'b0;
         end
         stNext.soEn = 1'b1;
         stNext.so = stNext.ackN;
      end else begin
         // split strobes: serialIn is write strobe, rdNRw is read strobe
         if (stReg.s2[`P_MUX] && fell(stReg, `P_SCLK)) begin
            stNext.addr = stReg.s2[`P_DATA +: 5];
         end
         if (!stReg.s2[`P_MUX] && (fell(stReg, `P_SIN) || fell(stReg, `P_RW))) begin
            stNext.addr = stReg.s2[`P_ADDR +: 5];
         end
         if (fell(stReg, `P_RW)) begin
            stNext.re = 1'b1;
            stNext.rdy = 1'b0;
         end
         if (stReg.load && !stReg.s2[`P_RW]) begin
            stNext.dOut = rdData;
            stNext.dOe = 1'b1;
            stNext.rdy = 1'b1;
            stNext.ph = PH_DRIVE;
         end
         if (rose(stReg, `P_RW)) begin
            stNext.dOe = 1'b0;
            stNext.ph = PH_IDLE;
         end
         if (rose(stReg, `P_SIN)) begin
            stNext.we = 1'b1;
            stNext.wData = stReg.s2[`P_DATA +: 8];
         end
         stNext.soEn = 1'b1;
         stNext.so = stNext.rdy;
      end
   end

   ////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stReg <= '0;
         stReg.s1 <= '1;
         stReg.s2 <= '1;
         stReg.s3 <= '1;
         stReg.ph <= PH_IDLE;
         stReg.ackN <= 1'b1;
         stReg.rdy <= 1'b1;
      end else begin
         stReg <= stNext;
      end
   end

   // register store
   reg_store uStore (
      .clk(clk),
      .we(stReg.we),
      .rdEn(stReg.re),
      .addr(stReg.addr),
      .wData(stReg.wData),
      .rData(rdData)
   );

   ////////////////////////////////////////////////////////////////
   // pin outputs
   assign dataOut = stReg.dOut;
   assign dataOe = stReg.dOe;
   assign serialOut = stReg.so;
   assign serialOutEn = stReg.soEn;
   assign intOut = 1'b0; // open drain: only ever pulls low
   assign intOe = |irqSrc;

   ////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wrStrobeRise;
      !stReg.s2[`P_HW] && !stReg.s2[`P_CS] && !stReg.s2[`P_SER] && rose(stReg, `P_SIN)
         && (stReg.s2[`P_STYLE] || !stReg.s2[`P_RW]);
   endsequence
   sequence s_cmdDone;
      stReg.ph == PH_CMD && rose(stReg, `P_SCLK) && stReg.cnt == `BITS_LAST_CMD;
   endsequence

   property p_hwQuiet;
      stReg.s2[`P_HW] |=> !dataOe && !serialOutEn && !stReg.we;
   endproperty
   a_hwQuiet: assert property (p_hwQuiet) else $error("pins active in hardware mode");
   property p_strobeWrite;
      s_wrStrobeRise |=> stReg.we && stReg.wData == $past(stReg.s2[7:0]);
   endproperty
   a_strobeWrite: assert property (p_strobeWrite) else $error("strobe rise did not write");
   property p_serialWriteQuiet;
      stReg.s2[`P_SER] && !stReg.isRead |-> !serialOutEn;
   endproperty
   a_serialWriteQuiet: assert property (p_serialWriteQuiet) else $error("serial out driven in write");
   property p_cmdQuiet;
      stReg.ph == PH_CMD |-> !serialOutEn;
   endproperty
   a_cmdQuiet: assert property (p_cmdQuiet) else $error("serial out driven during command");
   property p_readDrive;
      s_cmdDone ##0 stReg.shIn[6] ##1 !stReg.s2[`P_CS] |-> serialOutEn;
   endproperty
   a_readDrive: assert property (p_readDrive) else $error("serial read not driven");
   property p_bitIn;
      stReg.s2[`P_SER] && !stReg.s2[`P_CS] && !stReg.s2[`P_HW] && rose(stReg, `P_SCLK)
         |=> stReg.shIn[0] == $past(stReg.s2[`P_SIN]);
   endproperty
   a_bitIn: assert property (p_bitIn) else $error("serial bit not captured");
   property p_ackRead;
      !stReg.s2[`P_SER] && !stReg.s2[`P_STYLE] && !stReg.ackN && stReg.s2[`P_RW] && !stReg.s2[`P_CS]
         && !stReg.s2[`P_HW] |-> dataOe && !serialOut;
   endproperty
   a_ackRead: assert property (p_ackRead) else $error("ack without read data");
   property p_rdyWait;
      $rose(stReg.re) && stReg.s2[`P_STYLE] && !stReg.s2[`P_SER] |-> !stReg.rdy ##2 stReg.rdy;
   endproperty
   a_rdyWait: assert property (p_rdyWait) else $error("ready wait state wrong");
   property p_int;
      intOe == (irqSrc != 3'b000) && !intOut;
   endproperty
   a_int: assert property (p_int) else $error("interrupt pin wrong");
endmodule

/* File: rtl/host_port_defs.svh */
// host_port_defs.svh - bit positions of the sampled pin vector
// assumes: included by the host port and its package users
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH
`define PIN_W 23
`define P_DATA 0
`define P_ADDR 8
`define P_RW 13
`define P_SIN 14
`define P_SCLK 15
`define P_CS 16
`define P_HW 17
`define P_SER 18
`define P_MUX 19
`define P_STYLE 20
`define P_OES 21
`define P_SPARE 22
`define ADDR_W 5
`define MEM_DEPTH 32
`define BITS_LAST_CMD 4'h7
`define BITS_LAST_DATA 4'hf
`define CNT_FIRST_DATA 4'h8
`endif

/* File: rtl/host_port_pkg.sv */
// host_port_pkg.sv - types shared by the host port files
// assumes: nothing beyond the defs header
package host_port_pkg;
   // transaction phase, one-hot
   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_CMD = 4'b0010,
      PH_DATA = 4'b0100,
      PH_DRIVE = 4'b1000
   } phase_t;
   typedef logic [7:0] byte_t;
endpackage

/* File: rtl/reg_store.sv */
// reg_store.sv - 32 x 8 store behind the host port
// assumes: single clock, read data registered one cycle after rdEn
`timescale 1ns/1ps
`include "host_port_defs.svh"
module reg_store (
   input wire logic clk, // system clock
   input wire logic we, // write enable
   input wire logic rdEn, // read enable
   input wire logic [4:0] addr, // word address
   input wire host_port_pkg::byte_t wData, // write data
   output host_port_pkg::byte_t rData // registered read data
);
   import host_port_pkg::*;
   byte_t mem [`MEM_DEPTH];
   // one port, a write and a read can both happen in one cycle
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wData;
      end
      if (rdEn) begin
         rData <= mem[addr];
      end
   end
endmodule

/* File: dv/host_model.sv */
// host_model.sv - host processor model on the host port pins
// assumes: one task at a time; pins move 1 ns after clk rises
`timescale 1ns/1ps
module host_model (
   input wire logic clk, // system clock
   output logic csN, // chip select
   output logic sclkAleAsN, // shift clock / addr strobe
   output logic serialIn, // serial data / strobe
   output logic rdNRw, // read strobe / r-w select
   output logic [4:0] addrIn, // address bus
   output logic [7:0] dataIn, // data bus out
   input wire host_port_pkg::byte_t dataOut, // data bus in
   input wire logic dataOe, // device drives bus
   input wire logic serialOut, // data / ready / ack
   input wire logic serialOutEn, // device drives pin
   output logic [31:0] res, // flags, fall samples and byte
   output logic resStb // toggles per access
);
   import host_port_pkg::*;
   ////////////////////////////////////////////////////////////
   // idle: strobes high, shift clock still and low
   initial begin
      {csN, sclkAleAsN, serialIn, rdNRw, resStb} = 5'b10110;
      {addrIn, dataIn, res} = '0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // serial frame msb first, pins sampled just before each rise
   task automatic ser(input logic rd, input logic [4:0] a, input byte_t d);
      logic [15:0] w, m;
      byte_t q, q2;
      w = {rd, 2'b00, a, d};
      csN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serialIn = w[i];
         tick(4);
         m[i] = serialOutEn;
         q = {q[6:0], serialOut};
         sclkAleAsN = 1'b1;
         tick(4);
         // second look just before the fall tells the shifting edges apart
         q2 = {q2[6:0], serialOut};
         sclkAleAsN = 1'b0;
      end
      tick(4);
      {csN, serialIn} = 2'b11;
      tick(8);
      res = {m, rd ? {1'b0, q2[7:1]} : 8'h00, rd ? q : 8'h00};
      resStb = ~resStb;
   endtask
   // parallel access; decoy on the unused address source
   task automatic par(input logic sp, input logic mx, input logic rd, input logic [4:0] a, input byte_t d);
      logic [1:0] m = 2'b00;
      int n = 0;
      byte_t q;
      {csN, sclkAleAsN, rdNRw} = {1'b0, 1'b1, sp | rd};
      // top bus line differs from one access to the next
      {addrIn, dataIn} = {mx ? ~a : a, resStb, 2'b01, a};
      tick(2);
      if (mx) begin
         sclkAleAsN = 1'b0;
         tick(4);
         sclkAleAsN = 1'b1;
      end
      dataIn = d;
      // read strobe held low for the read, else one strobe pulse
      if (sp && rd) begin
         rdNRw = 1'b0;
      end else begin
         serialIn = 1'b0;
         tick(4);
         serialIn = 1'b1;
      end
      // wait out a low ready, or wait for acknowledge low
      while ((!sp || rd) && n < 20 && !(serialOutEn === 1'b1 && serialOut === sp && (dataOe === 1'b1 || !rd))) begin
         m[1] = m[1] | (sp && serialOutEn === 1'b1 && serialOut === 1'b0);
         tick(1);
         n++;
      end
      m[0] = n >= 20;
      q = rd ? dataOut : 8'h00;
      // read strobe ends here; a direction select holds until chip select rises
      rdNRw = rdNRw | sp;
      tick(2);
      {csN, dataIn, rdNRw} = {1'b1, ~dataIn, 1'b1};
      tick(4);
      res = {22'h00_0000, m, q};
      resStb = ~resStb;
   endtask
endmodule

/* File: dv/host_port_tb_top.sv */
// host_port_tb_top.sv - self-checking bench of the host port
// assumes: host_model does all pin work; results return in issue order
`timescale 1ns/1ps
module host_port_tb_top;
   import host_port_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, hwMode, serialMode, muxMode;
   logic busStyleSelect, outputEdgeSelect;
   logic [2:0] irqSrc;
   logic csN, sclkAleAsN, serialIn, rdNRw, dataOe, serialOut, serialOutEn, intOut, intOe, resStb;
   logic [4:0] addrIn, a;
   byte_t dataIn, dataOut, mem[32];
   logic [31:0] res, expQ[$];
   logic [31:0] rnd = 32'h1af1_826d;
   int n_fail = 0, cmp_count = 0;
   ////////////////////////////////////////////////////////////
   // device and host
   host_port u_host_port (.clk, .rst_n, .hwMode, .serialMode, .muxMode, .busStyleSelect, .outputEdgeSelect,
      .csN, .sclkAleAsN, .serialIn, .rdNRw, .addrIn, .dataIn, .dataOut, .dataOe, .serialOut, .serialOutEn,
      .irqSrc, .intOut, .intOe);
   host_model u_host_model (.clk, .csN, .sclkAleAsN, .serialIn, .rdNRw, .addrIn, .dataIn, .dataOut, .dataOe,
      .serialOut, .serialOutEn, .res, .resStb);
   // 25 ns clock
   always #12.5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // note the expected result, then run one access on the pins
   task automatic xfer(input logic rd);
      byte_t d, e;
      rnd = lfsr(rnd);
      d = rnd[15:8];
      if (!rd)
         mem[a] = d;
      // fall samples: bits 7..1 when shifting on falls, bits 6..0 when on rises
      e = outputEdgeSelect ? {1'b0, mem[a][7:1]} : {1'b0, mem[a][6:0]};
      if (serialMode)
         expQ.push_back({rd ? 16'h00ff : 16'h0000, rd ? e : 8'h00, rd ? mem[a] : 8'h00});
      else
         expQ.push_back({22'h00_0000, busStyleSelect & rd, 1'b0, rd ? mem[a] : 8'h00});
      if (serialMode)
         u_host_model.ser(rd, a, d);
      else
         u_host_model.par(busStyleSelect, muxMode, rd, a, d);
   endtask
   // watchdog, far beyond the roughly 1500 cycles of the run
   initial begin
      #200_000;
      n_fail++;
      end_of_test();
   end
   // reset, interrupt table, serial, four parallel styles, strapped mode
   initial begin
      {hwMode, serialMode, muxMode, busStyleSelect, outputEdgeSelect} = 5'h08;
      irqSrc = 3'h0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      u_host_model.tick(1);
      chk(32'({dataOe, serialOutEn}), 32'h0000_0000);
      // every source pattern once, then random ones
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         irqSrc = i < 8 ? 3'(i) : rnd[2:0];
         u_host_model.tick(1);
         chk(32'({intOut, intOe}), 32'(irqSrc != 3'h0));
      end
      for (int k = 0; k < 6; k++) begin
         {serialMode, muxMode, busStyleSelect} = k < 2 ? 3'b100 : {1'b0, 2'(k - 2)};
         outputEdgeSelect = k[0];
         u_host_model.tick(6);
         repeat (2) begin
            rnd = lfsr(rnd);
            a = rnd[4:0];
            xfer(1'b0);
            xfer(1'b1);
         end
      end
      hwMode = 1'b1;
      u_host_model.tick(6);
      expQ.push_back(32'h0000_0000);
      u_host_model.par(1'b1, muxMode, 1'b0, a, ~mem[a]);
      hwMode = 1'b0;
      u_host_model.tick(6);
      xfer(1'b1);
      u_host_model.tick(2);
      end_of_test();
   end
   // oldest note against each finished access
   always @(resStb)
      if (rst_n) chk(res, expQ.pop_front());
endmodule
